// ---- logic/irq_flag_regs.sv ----
// Interrupt flag and enable registers behind a classic Wishbone slave.
// Assumes 32-bit data, byte lane 0 for register data, ADR_W of 18 or more.
//
// Summary of operation
// [R1] Second register bit 5 enables fault interrupt
// [R2] Second register bit 4 flags supply fault
// [R3] Second register bit 3 enables two-wire interrupt
// [R4] Bit 2 sets on done, clears on start
// [R5] Second register bit 1 enables comparator interrupt
// [R6] Second register bit 0 flags comparator event
// [R7] First register bit 5 enables clock interrupt
// [R8] First register bit 4 clock flag, read-clear
// [R9] First register bit 1 enables keys interrupt
// [R10] First register bit 0 keys flag, read-clear
// [R11] First register bit 7 drives power-down mux
// [R12] Request when any flag and enable set
// [R13] Unused bits read zero, writes ignored
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps

module irq_flag_regs #(
  parameter int ADR_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Peripheral event sources, any clock
  input wire logic cal_event_i,
  input wire logic sbus_event_i,
  input wire logic key_detect_i,
  input wire logic supply_fault_i,
  input wire logic comparator_i,
  input wire logic twowire_done_i,
  input wire logic twowire_start_i,
  // Results
  output logic irq_req_o,
  output logic irq_o,
  output logic powerdown_mux_sel_o
);
  import irq_regs_pkg::*;

  // Register select codes from the address decoder
  localparam logic [3:0] SEL_CTL5 = 4'h1;
  localparam logic [3:0] SEL_CTL6 = 4'h2;
  localparam logic [3:0] SEL_STAT = 4'h4;
  localparam logic [3:0] SEL_MASK = 4'h8;

  reg_state_s s;
  reg_state_s next_s;
  ev_vec_t raw;
  irq_event_if ev_bus ();

  // Gather the sources into one vector for the synchroniser
  always_comb
  begin
    raw = '0;
    raw[`EV_CAL] = cal_event_i;
    raw[`EV_SBUS] = sbus_event_i;
    raw[`EV_KEYS] = key_detect_i;
    raw[`EV_FAULT] = supply_fault_i;
    raw[`EV_CMP] = comparator_i;
    raw[`EV_TWI_DONE] = twowire_done_i;
    raw[`EV_TWI_START] = twowire_start_i;
  end

  irq_event_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .raw_i(raw),
    .ev(ev_bus.src)
  );

  // One-hot register select; zero for an unmapped word
  function automatic logic [3:0] decode(input logic [ADR_W-1:0] adr);
    logic [`IDX_W-1:0] idx;
    idx = adr[`IDX_W+1:2];
    if (adr[1:0] != 2'h0)
      decode = 4'h0;
    else if (idx == `IDX_RTC_USB_KEYS)
      decode = SEL_CTL5;
    else if (idx == `IDX_FAULT_TWI_CMP)
      decode = SEL_CTL6;
    else if (idx == `IDX_EVT_STATUS)
      decode = SEL_STAT;
    else if (idx == `IDX_EVT_MASK)
      decode = SEL_MASK;
    else
      decode = 4'h0;
  endfunction

  // Read data for a selected register, bits above eight are zero
  function automatic logic [31:0] read_word(input logic [3:0] hit, input reg_state_s st);
    logic [7:0] b;
    b = 8'h00;
    if (hit == SEL_CTL5)
      b = st.ctl5;
    else if (hit == SEL_CTL6)
      b = st.ctl6;
    else if (hit == SEL_STAT)
      b = {2'h0, st.stat};
    else if (hit == SEL_MASK)
      b = {2'h0, st.mask};
    read_word = {24'h000000, b};
  endfunction

  // Next state: bus access first, then clears, then hardware sets
  always_comb
  begin
    logic [3:0] hit;
    logic take;
    logic wr;
    logic rd;
    logic [7:0] wb;
    ev_vec_t p;
    hit = decode(adr_i);
    take = cyc_i & stb_i & ~s.ack;
    wr = take & we_i & sel_i[0];
    rd = take & ~we_i;
    wb = dat_i[7:0];
    p = ev_bus.pulse;
    next_s = s;

    // Ack one cycle after the request, dropped the cycle after
    next_s.ack = take;
    if (rd)
    begin
      next_s.dat = read_word(hit, s);
    end

    // Enable and mux bits; flags and spare bits keep their value
    if (wr && hit == SEL_CTL5)
    begin
      next_s.ctl5 = (s.ctl5 & ~`WMASK_5) | (wb & `WMASK_5); // see [R7] see [R9] see [R11] see [R13]
    end
    if (wr && hit == SEL_CTL6)
    begin
      next_s.ctl6 = (s.ctl6 & ~`WMASK_6) | (wb & `WMASK_6); // see [R1] see [R3] see [R5] see [R13]
    end
    if (wr && hit == SEL_MASK)
    begin
      next_s.mask = wb[`STAT_W-1:0];
    end

    // Write one to clear in the event status register
    if (wr && hit == SEL_STAT)
    begin
      next_s.stat = s.stat & ~wb[`STAT_W-1:0];
    end

    // Read clears the flags of the register just read, except the two-wire done flag
    if (rd && hit == SEL_CTL5)
    begin
      next_s.ctl5[`B5_CAL_FLAG] = 1'b0; // see [R8]
      next_s.ctl5[`B5_SBUS_FLAG] = 1'b0;
      next_s.ctl5[`B5_KEYS_FLAG] = 1'b0; // see [R10]
    end
    if (rd && hit == SEL_CTL6)
    begin
      next_s.ctl6[`B6_FAULT_FLAG] = 1'b0;
      next_s.ctl6[`B6_CMP_FLAG] = 1'b0;
    end

    // Two-wire done flag is cleared by the next transaction start
    if (p[`EV_TWI_START])
    begin
      next_s.ctl6[`B6_TWI_FLAG] = 1'b0; // see [R4]
    end

    // Hardware sets win over any clear in the same cycle
    if (p[`EV_CAL])
    begin
      next_s.ctl5[`B5_CAL_FLAG] = 1'b1; // see [R8]
    end
    if (p[`EV_SBUS])
    begin
      next_s.ctl5[`B5_SBUS_FLAG] = 1'b1; // see [R12]
    end
    if (p[`EV_KEYS])
    begin
      next_s.ctl5[`B5_KEYS_FLAG] = 1'b1; // see [R10]
    end
    if (p[`EV_FAULT])
    begin
      next_s.ctl6[`B6_FAULT_FLAG] = 1'b1; // see [R2]
    end
    if (p[`EV_CMP])
    begin
      next_s.ctl6[`B6_CMP_FLAG] = 1'b1; // see [R6]
    end
    if (p[`EV_TWI_DONE])
    begin
      next_s.ctl6[`B6_TWI_FLAG] = 1'b1; // see [R4]
    end

    // Sticky event copy for the masked interrupt line
    next_s.stat = next_s.stat | p[`STAT_W-1:0];

    // Flag-and-enable request, taken from next values so it is a flop
    next_s.req =
      (next_s.ctl5[`B5_CAL_FLAG] & next_s.ctl5[`B5_CAL_EN]) | // see [R12] see [R7]
      (next_s.ctl5[`B5_SBUS_FLAG] & next_s.ctl5[`B5_SBUS_EN]) |
      (next_s.ctl5[`B5_KEYS_FLAG] & next_s.ctl5[`B5_KEYS_EN]) | // see [R9]
      (next_s.ctl6[`B6_FAULT_FLAG] & next_s.ctl6[`B6_FAULT_EN]) | // see [R1]
      (next_s.ctl6[`B6_TWI_FLAG] & next_s.ctl6[`B6_TWI_EN]) | // see [R3]
      (next_s.ctl6[`B6_CMP_FLAG] & next_s.ctl6[`B6_CMP_EN]); // see [R5]

    // Level interrupt while any unmasked status bit is set
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s.ctl5 <= `RST_CTL;
      s.ctl6 <= `RST_CTL;
      s.stat <= `RST_STAT;
      s.mask <= `RST_MASK;
      s.ack <= 1'b0;
      s.dat <= 32'h00000000;
      s.irq <= 1'b0;
      s.req <= 1'b0;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign irq_req_o = s.req;
  assign irq_o = s.irq;
  assign powerdown_mux_sel_o = s.ctl5[`B5_POWERDOWN_MUX_SEL]; // see [R11]
endmodule

// ---- logic/irq_regs_cfg.svh ----
// Constants for the interrupt flag and enable register block.
// Assumes a 32-bit classic Wishbone bus; byte address is four times the index.
`ifndef IRQ_REGS_CFG_SVH
`define IRQ_REGS_CFG_SVH

// Register indices, byte address = index * 4
`define IDX_W 16
`define IDX_RTC_USB_KEYS 16'hFF94
`define IDX_FAULT_TWI_CMP 16'hFF95
`define IDX_EVT_STATUS 16'hFF96
`define IDX_EVT_MASK 16'hFF97

// Fields of the clock/serial-bus/keys register
`define B5_POWERDOWN_MUX_SEL 7
`define B5_CAL_EN 5
`define B5_CAL_FLAG 4
`define B5_SBUS_EN 3
`define B5_SBUS_FLAG 2
`define B5_KEYS_EN 1
`define B5_KEYS_FLAG 0

// Fields of the fault/two-wire/comparator register
`define B6_FAULT_EN 5
`define B6_FAULT_FLAG 4
`define B6_TWI_EN 3
`define B6_TWI_FLAG 2
`define B6_CMP_EN 1
`define B6_CMP_FLAG 0

// Software-writable bits of each control register
`define WMASK_5 8'hAA
`define WMASK_6 8'h2A

// Event numbers on the event bus; status and mask use the first six
`define EV_N 7
`define EV_CAL 0
`define EV_SBUS 1
`define EV_KEYS 2
`define EV_FAULT 3
`define EV_CMP 4
`define EV_TWI_DONE 5
`define EV_TWI_START 6
`define STAT_W 6

// Reset values
`define RST_CTL 8'h00
`define RST_STAT 6'h00
`define RST_MASK 6'h00

`endif

// ---- logic/irq_regs_pkg.sv ----
// Types shared by the interrupt flag block and its event synchroniser.
// Assumes irq_regs_cfg.svh is on the include path.
`include "irq_regs_cfg.svh"

package irq_regs_pkg;

  typedef logic [`EV_N-1:0] ev_vec_t;

  // Synchroniser state: two flops per source, then one for edge finding
  typedef struct packed {
    ev_vec_t meta;
    ev_vec_t sync;
    ev_vec_t prev;
  } sync_state_s;

  // Register block state
  typedef struct packed {
    logic [7:0] ctl5;
    logic [7:0] ctl6;
    logic [`STAT_W-1:0] stat;
    logic [`STAT_W-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic req;
  } reg_state_s;

endpackage

// ---- logic/irq_event_if.sv ----
// Event pulse bus from the synchroniser to the register block.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface irq_event_if;
  irq_regs_pkg::ev_vec_t pulse;
  modport src (output pulse);
  modport snk (input pulse);
endinterface

// ---- logic/irq_event_sync.sv ----
// Two-flop synchroniser and rising-edge detector for peripheral events.
// Assumes raw inputs may come from any clock; pulses are one cycle wide.
`timescale 1ns/1ps

module irq_event_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire irq_regs_pkg::ev_vec_t raw_i,
  irq_event_if.src ev
);
  import irq_regs_pkg::*;

  sync_state_s s;
  sync_state_s next_s;

  // Meta feeds only the second flop; edges are taken after it
  always_comb
  begin
    next_s = s;
    next_s.meta = raw_i;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // A level held high gives one event only
  assign ev.pulse = s.sync & ~s.prev;
endmodule

// ---- test/irq_flag_regs_chk.sv ----
// Checker on the flag block's bus and level outputs.
// Assumes one clock; bound from the bench top.
`timescale 1ns/1ps
module irq_flag_regs_chk #(
  parameter int ADR_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic powerdown_mux_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rq;
  // Request taken at this edge
  assign rq = cyc_i && stb_i && !ack_o && ce_i;
  property p_ack; rq |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_noack; !rq |=> !ack_o; endproperty
  a_noack: assert property (p_noack) else $error("ack without request");
  property p_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read lanes not zero");
  property p_pdm;
    rq && we_i && sel_i[0] && adr_i == 18'h3FE50 |=> powerdown_mux_sel_o == $past(dat_i[7]);
  endproperty
  a_pdm: assert property (p_pdm) else $error("mux select not written");
  property p_b5; ack_o && !$past(we_i) && $past(adr_i) == 18'h3FE50 |-> !dat_o[6]; endproperty
  a_b5: assert property (p_b5) else $error("unused bit reads one");
  property p_b6;
    ack_o && !$past(we_i) && $past(adr_i) == 18'h3FE54 |-> dat_o[7:6] == 2'h0;
  endproperty
  a_b6: assert property (p_b6) else $error("unused bits read one");
  property p_unm;
    ack_o && !$past(we_i) && $past(adr_i[17:4]) != 14'h3FE5 |-> dat_o == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_msk;
    rq && we_i && sel_i[0] && adr_i == 18'h3FE5C && dat_i[5:0] == 6'h0 |=> !irq_o;
  endproperty
  a_msk: assert property (p_msk) else $error("masked request still high");
endmodule

// ---- test/irq_evt_src.sv ----
// Peripheral event source: each fire request gives a three-cycle high level.
// Assumes requests on one line are spaced by six cycles or more.
`timescale 1ns/1ps
module irq_evt_src (
  input wire logic clk_i,
  input wire logic [6:0] fire_i,
  output logic [6:0] lvl_o
);
  logic [6:0] h1 = 7'h0, h2 = 7'h0, h3 = 7'h0;
  // Long enough to pass the two-flop synchroniser
  always @(posedge clk_i)
  begin
    h1 <= fire_i;
    h2 <= h1;
    h3 <= h2;
  end
  assign lvl_o = h1 | h2 | h3;
endmodule

// ---- test/test_irq_flag_regs.sv ----
// Bench for the flag block: Wishbone tasks, event source, queued reads.
// Assumes checker and event source are compiled before this file.
`timescale 1ns/1ps
module test_irq_flag_regs;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack_o, irq_req_o, irq_o, pdm;
  logic ce = 1;
  logic [17:0] adr = 0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 0, dat_o;
  logic [6:0] fire = 0, lvl;
  logic [7:0] q[$];
  logic [7:0] fl[6] = '{8'h10, 8'h04, 8'h01, 8'h10, 8'h01, 8'h04};
  int error_cnt = 0, num_checks = 0;
  localparam logic [17:0] C5 = 18'h3FE50, C6 = 18'h3FE54, ST = 18'h3FE58, MK = 18'h3FE5C;
  irq_flag_regs #(.ADR_W(18)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .cal_event_i(lvl[0]), .sbus_event_i(lvl[1]),
    .key_detect_i(lvl[2]), .supply_fault_i(lvl[3]), .comparator_i(lvl[4]),
    .twowire_done_i(lvl[5]), .twowire_start_i(lvl[6]), .irq_req_o(irq_req_o),
    .irq_o(irq_o), .powerdown_mux_sel_o(pdm));
  irq_evt_src src_u (.clk_i(clk_i), .fire_i(fire), .lvl_o(lvl));
  initial forever #5 clk_i = ~clk_i;
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; the idle edge first keeps cyc low between cycles
  task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do @(posedge clk_i); while (ack_o !== 1'h1 && ++n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      end_of_test();
    end
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    q.push_back(e);
    wb(0, a, 8'h0);
  endtask
  task automatic fire_ev(input int n);
    fire[n] <= 1;
    @(posedge clk_i);
    fire[n] <= 0;
    repeat (6) @(posedge clk_i);
  endtask
  // Read data is matched with the oldest note at the ack edge
  always @(posedge clk_i)
    if (ack_o === 1'h1 && we === 1'h0)
      chk(dat_o[7:0], q.pop_front());
  initial
  begin
    int i;
    logic [7:0] d;
    i = $urandom(71553);
    repeat (2) @(posedge clk_i);
    chk({irq_o, irq_req_o, pdm}, 8'h0);
    rst_i <= 0;
    rd(C5, 8'h0);
    rd(C6, 8'h0);
    rd(ST, 8'h0);
    rd(MK, 8'h0);
    // Flags and spare bits refuse writes
    wb(1, C5, 8'hFF);
    wb(1, C6, 8'hFF);
    chk(pdm, 8'h1);
    rd(C5, 8'hAA);
    rd(C6, 8'h2A);
    sel <= 4'h0;
    wb(1, C6, 8'h0);
    sel <= 4'hF;
    rd(C6, 8'h2A);
    rd(18'h00100, 8'h0);
    // Each of the six flag sources sets its flag; all but two-wire done clear on read
    for (i = 0; i < 6; i++)
    begin
      fire_ev(i);
      chk(irq_req_o, 8'h1);
      d = (i < 3) ? 8'hAA : 8'h2A;
      // Misaligned word is not decoded, so it must neither read nor clear
      rd((i < 3 ? C5 : C6) | 18'h1, 8'h0);
      rd(i < 3 ? C5 : C6, d | fl[i]);
      rd(i < 3 ? C5 : C6, d | (i == 5 ? fl[i] : 8'h0));
      chk(irq_req_o, i == 5);
    end
    fire_ev(6);
    chk(irq_req_o, 8'h0);
    rd(C6, 8'h2A);
    // Enable low freezes the synchroniser, so a short event is lost
    ce <= 0;
    fire_ev(0);
    ce <= 1;
    repeat (4) @(posedge clk_i);
    chk(irq_req_o, 8'h0);
    rd(C5, 8'hAA);
    // Sticky status, gated by the mask, cleared by writing one
    rd(ST, 8'h3F);
    chk(irq_o, 8'h0);
    wb(1, MK, 8'h01);
    chk(irq_o, 8'h1);
    wb(1, MK, 8'h00);
    chk(irq_o, 8'h0);
    wb(1, MK, 8'h01);
    wb(1, ST, 8'h01);
    chk(irq_o, 8'h0);
    rd(ST, 8'h3E);
    repeat (4)
    begin
      d = 8'($urandom);
      wb(1, MK, d);
      rd(MK, d & 8'h3F);
      chk(irq_o, |d[5:1]);
    end
    end_of_test();
  end
endmodule
bind irq_flag_regs irq_flag_regs_chk #(.ADR_W(ADR_W)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
  .powerdown_mux_sel_o(powerdown_mux_sel_o));
